// ===== shared/acb_pkg.sv
// What this block does
// - the completion flag is cleared by hardware only when a conversion starts, never during sampling; a software write to adc_control_1 can also clear it.
// - the completion flag is set when a conversion finishes and stays set until the next conversion begins or software writes it to 0 in adc_control_1.
// - with split fill on, results fill the first buffer half until an interrupt, then the second half, alternating.
// - with split fill off, results restart at the first buffer location after each interrupt.
// - with alternate select on, set A and set B input selects are used on alternate samples.
// - with alternate select off, only set A input selects are used, except for one set B sample if set B was due when it was switched off.
// - the samples-per-interrupt count sets after how many conversions the interrupt flag rises.
// - with the dma path off, sixteen result buffers are written in sequence whatever input was measured.
package acb_pkg;
  localparam logic [11:0] ctrl1_off = 12'h000;
  localparam logic [11:0] ctrl2_off = 12'h004;
  localparam logic [11:0] chsel_off = 12'h008;
  localparam logic [11:0] tim_off = 12'h00c;
  localparam logic [11:0] buf_off = 12'h040;
  // adc_control_1 fields
  localparam int c1_done_bit = 0;
  localparam int c1_sample_start_bit_bit = 1;
  localparam int c1_asam_bit = 2;
  localparam int c1_on_bit = 15;
  // adc_control_2 fields
  localparam int c2_alternate_input_select_bit = 0;
  localparam int c2_buffer_fill_split_bit = 1;
  localparam int c2_samples_per_interrupt_lsb = 2;
  localparam int c2_dma_bit = 7;
  localparam int c2_flag_bit = 8;
  localparam int c2_half_bit = 9;
  localparam logic [15:0] ctrl1_rst = 16'h0000;
  localparam logic [15:0] ctrl2_rst = 16'h0000;
  localparam logic [15:0] chsel_rst = 16'h0000;
  localparam logic [7:0] sample_start_bit_cyc_rst = 8'h04;
  localparam logic [7:0] conv_cyc_rst = 8'h0c;
  localparam int buf_depth = 16;
  localparam int res_w = 12;
  typedef enum logic [1:0] {acb_idle, acb_sample, acb_convert} acb_state_e;
  typedef struct packed {
    logic start;
    logic [4:0] chan;
    logic sel_b;
  } acb_conv_s;
endpackage

// ===== rtl/acb_mem.sv
module acb_mem (
  input wire logic pclk,
  input wire logic ce,
  input wire logic we,
  input wire logic [3:0] waddr,
  input wire logic [11:0] wdata,
  input wire logic [3:0] raddr,
  output logic [11:0] rdata
);
  logic [11:0] mem [0:15];
  always_ff @(posedge pclk) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end
endmodule

// ===== rtl/acb_ctrl.sv
// Chosen here: the placing of the registers and the APB register port.
module acb_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output acb_pkg::acb_conv_s conv_o,
  input wire logic conv_valid,
  input wire logic [11:0] conv_result
);
  acb_pkg::acb_state_e st_r, st_nxt;
  logic [15:0] c1_r, c1_nxt, c2_r, c2_nxt, cs_r, cs_nxt, tim_r, tim_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [4:0] smp_r, smp_nxt;
  logic [3:0] ptr_r, ptr_nxt;
  logic altb_r, altb_nxt, half_r, half_nxt, rd_r, rd_nxt;
  acb_pkg::acb_conv_s conv_nxt;
  logic wr, rd, buf_hit, conv_done, conv_start, irq_evt;
  logic [11:0] mem_rdata;
  logic [31:0] rdata_nxt;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction

  // one wait state on buffer reads so the memory register can fill
  assign buf_hit = paddr[11:6] == acb_pkg::buf_off[11:6];
  assign wr = psel && penable && pwrite && clk_en;
  assign rd = psel && !pwrite;
  assign pready = !(buf_hit && rd && !rd_r);
  assign pslverr = 1'b0;
  // a result arriving after the block is switched off is dropped
  assign conv_done = (st_r == acb_pkg::acb_convert) && conv_valid &&
    c1_r[acb_pkg::c1_on_bit];
  assign conv_start = conv_nxt.start;
  assign irq_evt = conv_done && (smp_r == c2_r[acb_pkg::c2_samples_per_interrupt_lsb +: 5]);

  acb_mem u_mem (
    .pclk(pclk),
    .ce(clk_en),
    .we(conv_done && !c2_r[acb_pkg::c2_dma_bit]),
    .waddr(ptr_r),
    .wdata(conv_result),
    .raddr(paddr[5:2]),
    .rdata(mem_rdata)
  );

  always_comb begin
    st_nxt = st_r;
    c1_nxt = c1_r;
    c2_nxt = c2_r;
    cs_nxt = cs_r;
    tim_nxt = tim_r;
    cnt_nxt = cnt_r;
    smp_nxt = smp_r;
    ptr_nxt = ptr_r;
    altb_nxt = altb_r;
    half_nxt = half_r;
    rd_nxt = psel && penable && !pready ? 1'b1 : 1'b0;
    conv_nxt = '0;
    conv_nxt.chan = altb_r ? cs_r[12:8] : cs_r[4:0];
    conv_nxt.sel_b = altb_r;
    rdata_nxt = prdata;
    // software writes first, hardware events below take priority
    if (wr) begin
      if (hit(paddr, acb_pkg::ctrl1_off)) c1_nxt = pwdata[15:0];
      if (hit(paddr, acb_pkg::ctrl2_off)) begin
        c2_nxt[7:0] = pwdata[7:0];
        c2_nxt[acb_pkg::c2_flag_bit] = c2_r[acb_pkg::c2_flag_bit] &
          pwdata[acb_pkg::c2_flag_bit];
      end
      if (hit(paddr, acb_pkg::chsel_off)) cs_nxt = pwdata[15:0];
      if (hit(paddr, acb_pkg::tim_off)) tim_nxt = pwdata[15:0];
    end
    if (!c1_r[acb_pkg::c1_on_bit]) begin
      st_nxt = acb_pkg::acb_idle;
    end else begin
      case (st_r)
        acb_pkg::acb_idle: begin
          if (c1_nxt[acb_pkg::c1_sample_start_bit_bit] || c1_r[acb_pkg::c1_asam_bit]) begin
            st_nxt = acb_pkg::acb_sample;
            cnt_nxt = tim_r[7:0];
            c1_nxt[acb_pkg::c1_sample_start_bit_bit] = 1'b1;
          end
        end
        acb_pkg::acb_sample: begin
          // flag is left alone while sampling
          if (cnt_r != 8'h00) begin
            cnt_nxt = cnt_r - 8'h01;
          end else begin
            st_nxt = acb_pkg::acb_convert;
            conv_nxt.start = 1'b1;
            c1_nxt[acb_pkg::c1_sample_start_bit_bit] = 1'b0;
            c1_nxt[acb_pkg::c1_done_bit] = 1'b0;
          end
        end
        acb_pkg::acb_convert: begin
          if (conv_valid) begin
            st_nxt = acb_pkg::acb_idle;
            c1_nxt[acb_pkg::c1_done_bit] = 1'b1;
            if (c2_r[acb_pkg::c2_alternate_input_select_bit]) altb_nxt = !altb_r;
            else altb_nxt = 1'b0;
            ptr_nxt = 4'(ptr_r + 4'h1);
            smp_nxt = 5'(smp_r + 5'h01);
            if (irq_evt) begin
              smp_nxt = 5'h00;
              c2_nxt[acb_pkg::c2_flag_bit] = 1'b1;
              if (c2_r[acb_pkg::c2_buffer_fill_split_bit]) begin
                half_nxt = !half_r;
                ptr_nxt = half_nxt ? 4'h8 : 4'h0;
              end else begin
                half_nxt = 1'b0;
                ptr_nxt = 4'h0;
              end
            end
          end
        end
        default: st_nxt = acb_pkg::acb_idle;
      endcase
    end
    c2_nxt[acb_pkg::c2_half_bit] = half_nxt;
    // load before the completing edge so prdata stands while pready is high
    if (psel && !pwrite && !(penable && pready)) begin
      rdata_nxt = 32'h0000_0000;
      if (hit(paddr, acb_pkg::ctrl1_off)) rdata_nxt[15:0] = c1_r;
      if (hit(paddr, acb_pkg::ctrl2_off)) rdata_nxt[15:0] = c2_r;
      if (hit(paddr, acb_pkg::chsel_off)) rdata_nxt[15:0] = cs_r;
      if (hit(paddr, acb_pkg::tim_off)) rdata_nxt[15:0] = tim_r;
      if (buf_hit) rdata_nxt[11:0] = mem_rdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= acb_pkg::acb_idle;
      c1_r <= acb_pkg::ctrl1_rst;
      c2_r <= acb_pkg::ctrl2_rst;
      cs_r <= acb_pkg::chsel_rst;
      tim_r <= {acb_pkg::conv_cyc_rst, acb_pkg::sample_start_bit_cyc_rst};
      cnt_r <= 8'h00;
      smp_r <= 5'h00;
      ptr_r <= 4'h0;
      altb_r <= 1'b0;
      half_r <= 1'b0;
      rd_r <= 1'b0;
      conv_o <= '0;
      prdata <= 32'h0000_0000;
    end else if (clk_en) begin
      st_r <= st_nxt;
      c1_r <= c1_nxt;
      c2_r <= c2_nxt;
      cs_r <= cs_nxt;
      tim_r <= tim_nxt;
      cnt_r <= cnt_nxt;
      smp_r <= smp_nxt;
      ptr_r <= ptr_nxt;
      altb_r <= altb_nxt;
      half_r <= half_nxt;
      rd_r <= rd_nxt;
      conv_o <= conv_nxt;
      prdata <= rdata_nxt;
    end
  end

  a_done_clr_start: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && $fell(c1_r[0]) && !$past(wr && paddr == acb_pkg::ctrl1_off)
    |-> $past(st_r) == acb_pkg::acb_sample)
    else $error("done cleared outside conversion start");
  a_done_set_end: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && conv_done && c1_r[15] |=> !clk_en || c1_r[0])
    else $error("done not set after conversion");
  a_done_hold: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == acb_pkg::acb_sample && cnt_r != 8'h00 && c1_r[0] |=> c1_r[0])
    else $error("done dropped during sampling");
  a_split_half: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && irq_evt && c2_r[1] && !half_r |=> ptr_r == 4'h8)
    else $error("split fill did not move to upper half");
  a_fill_restart: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && irq_evt && !c2_r[1] |=> ptr_r == 4'h0)
    else $error("fill did not restart at zero");
  a_alt_toggle: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && conv_done && c2_r[0] |=> altb_r != $past(altb_r))
    else $error("alternate select did not toggle");
  a_set_a_only: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && conv_done && !c2_r[0] |=> !altb_r)
    else $error("set b used without alternate mode");
  a_irq_count: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && irq_evt |=> c2_r[8] && smp_r == 5'h00)
    else $error("interrupt flag not raised at count");
  a_buf_seq: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && conv_done && !irq_evt |=> ptr_r == 4'($past(ptr_r) + 4'h1))
    else $error("buffer pointer not sequential");
  a_start_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && conv_o.start |=> !conv_o.start)
    else $error("start pulse longer than one cycle");
  a_split_back: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && irq_evt && c2_r[1] && half_r |=> ptr_r == 4'h0)
    else $error("split fill did not return to lower half");
  a_half_shown: assert property (@(posedge pclk) disable iff (!presetn)
    c2_r[9] == half_r)
    else $error("half status bit out of step");
  a_chan_pick: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en |=> conv_o.chan ==
    ($past(altb_r) ? $past(cs_r[12:8]) : $past(cs_r[4:0])))
    else $error("wrong channel select presented");
  a_sel_b_out: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en |=> conv_o.sel_b == $past(altb_r))
    else $error("set b marker out of step");
  a_flag_keep: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && c2_r[8] && !(wr && paddr == acb_pkg::ctrl2_off) |=> c2_r[8])
    else $error("interrupt flag lost without a clear");
  a_off_idle: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !c1_r[15] |=> st_r == acb_pkg::acb_idle)
    else $error("converter busy while switched off");
  a_sample_start_bit_stay: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && c1_r[15] && st_r == acb_pkg::acb_sample && cnt_r != 8'h00
    |=> st_r == acb_pkg::acb_sample)
    else $error("sample phase cut short");
  a_rdata_hold: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && psel && penable && pready && !pwrite |=> $stable(prdata))
    else $error("read data changed at completing edge");
endmodule

// ===== test/acb_ctrl_test.sv
module acb_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0;
  logic pwrite = 0, conv_valid = 0;
  logic [11:0] paddr = '0, conv_result = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr;
  acb_pkg::acb_conv_s conv_o;
  int n_mismatch = 0;
  int compares = 0;
  always #25 pclk = ~pclk;
  acb_ctrl i_acb_ctrl (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_o(conv_o), .conv_valid(conv_valid), .conv_result(conv_result));
  task finish_test;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task timeout(input int n, input int lim);
    if (n >= lim) begin
      n_mismatch++;
      finish_test;
    end
  endtask
  // request held until the edge that sees pready; prdata taken there
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    timeout(n, 20);
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    cmp(rd & m, e);
  endtask
  // keep=1 leaves done set so its survival through sampling is visible
  task conv(input logic keep, input logic [4:0] ch, input logic b,
            input logic [11:0] res);
    int n;
    n = 0;
    if (!keep) apb(1'b1, acb_pkg::ctrl1_off, 32'h8000);
    apb(1'b1, acb_pkg::ctrl1_off, 32'h8002 | {31'h0, keep});
    if (keep) rdc(acb_pkg::ctrl1_off, 32'h1, 32'h1);
    while (conv_o.start !== 1'b1 && n < 40) begin
      @(posedge pclk);
      #1;
      n++;
    end
    timeout(n, 40);
    cmp({27'h0, conv_o.chan}, {27'h0, ch});
    cmp({31'h0, conv_o.sel_b}, {31'h0, b});
    rdc(acb_pkg::ctrl1_off, 32'h1, 32'h0);
    @(posedge pclk);
    conv_valid <= 1'b1;
    conv_result <= res;
    @(posedge pclk);
    conv_valid <= 1'b0;
    rdc(acb_pkg::ctrl1_off, 32'h1, 32'h1);
  endtask
  task rst_cfg(input logic [31:0] c2);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdc(acb_pkg::ctrl2_off, 32'hffff, {16'h0, acb_pkg::ctrl2_rst});
    apb(1'b1, acb_pkg::tim_off, 32'h8);
    apb(1'b1, acb_pkg::chsel_off, 32'h0a03);
    apb(1'b1, acb_pkg::ctrl2_off, c2);
    rdc(acb_pkg::ctrl2_off, 32'hff, c2);
  endtask
  initial begin
    // split fill, alternate select, two conversions per interrupt
    rst_cfg(32'h7);
    conv(1'b0, 5'h03, 1'b0, 12'h111);
    rdc(acb_pkg::ctrl2_off, 32'h100, 32'h0);
    conv(1'b1, 5'h0a, 1'b1, 12'h222);
    rdc(acb_pkg::ctrl2_off, 32'h100, 32'h100);
    conv(1'b0, 5'h03, 1'b0, 12'h333);
    conv(1'b0, 5'h0a, 1'b1, 12'h444);
    conv(1'b0, 5'h03, 1'b0, 12'h555);
    rdc(acb_pkg::buf_off, 32'hfff, 32'h555);
    rdc(acb_pkg::buf_off + 12'h004, 32'hfff, 32'h222);
    rdc(acb_pkg::buf_off + 12'h020, 32'hfff, 32'h333);
    rdc(acb_pkg::buf_off + 12'h024, 32'hfff, 32'h444);
    $display("test split fill done");
    // second reset mid-run; restart fill, set A only
    rst_cfg(32'h4);
    conv(1'b0, 5'h03, 1'b0, 12'h0a1);
    conv(1'b0, 5'h03, 1'b0, 12'h0a2);
    conv(1'b0, 5'h03, 1'b0, 12'h0a3);
    rdc(acb_pkg::buf_off, 32'hfff, 32'h0a3);
    rdc(acb_pkg::buf_off + 12'h004, 32'hfff, 32'h0a2);
    rdc(12'h03c, 32'hffffffff, 32'h0);
    $display("test restart fill done");
    // a write while frozen must not land
    clk_en <= 1'b0;
    apb(1'b1, acb_pkg::ctrl2_off, 32'h3);
    clk_en <= 1'b1;
    rdc(acb_pkg::ctrl2_off, 32'hff, 32'h4);
    $display("test clock enable done");
    finish_test;
  end
endmodule
